// >>> rtl/prx_packet_rx.sv
`timescale 1ns/1ps
// How it works
// - Preamble and sync dropped; payload into FIFO.
// - End of packet raises ready, CRC pass.
// - CRC fail with autoclear: clear, restart.
// - Autoclear disabled: keep FIFO, ready only.
// - Hold after packet until RX mode is left; new one also needs empty FIFO.
// - FIFO readable in standby when enabled.
// - Only configured sync word starts a packet.
// - Sync detect starts payload, pulses sync flag.
// - Variable length accepted below limit only.
// - Length byte kept as first FIFO byte.
// - Mode 01: node address must match.
// - Mode 10: node or zero address.
// - Mode 11: node, zero or all-ones address.
// - Address filter receive only; byte kept.
// - Transmit appends two-byte checksum.
// - Receive recomputes checksum, records result.
// - Checksum bytes never reach the FIFO.
// - CCITT polynomial, preset and inverted.
// - Manchester: one is 10, zero is 01.
// - Manchester only over payload and checksum.
// - Nine-bit LFSR whitens payload and checksum.
module prx_packet_rx (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input prx_pkg::prx_mode_t mode_in,
  input wire logic chip_clk_in,
  input wire logic chip_data_in,
  input wire logic [31:0] sync_word_in,
  input wire logic [1:0] sync_size_in,
  input wire logic [1:0] fifo_size_in,
  input wire logic variable_length_in,
  input wire logic [6:0] payload_length_limit_in,
  input wire logic [1:0] address_filter_select_in,
  input wire logic [7:0] node_address_reg_in,
  input wire logic crc_check_enable_in,
  input wire logic crc_fail_autoclear_disable_in,
  input wire logic standby_fifo_access_in,
  input wire logic manchester_enable_in,
  input wire logic whitening_enable_in,
  input wire logic fifo_read_in,
  output logic [7:0] fifo_data_out,
  output logic fifo_empty_out,
  output logic payload_ready_flag_out,
  output logic crc_pass_flag_out,
  output logic sync_flag_out,
  output logic crc_status_bit_out,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic tx_chip_out,
  output logic tx_done_out
);
  import prx_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [31:0] sync_mask(input logic [1:0] sel);
    logic [31:0] m;
    m = 32'h0000_00FF;
    unique case (sel)
      2'b00: m = 32'h0000_00FF;
      2'b01: m = 32'h0000_FFFF;
      2'b10: m = 32'h00FF_FFFF;
      2'b11: m = 32'hFFFF_FFFF;
    endcase
    return m;
  endfunction

  function automatic logic addr_match(input logic [1:0] sel,
                                      input logic [7:0] a,
                                      input logic [7:0] node);
    logic ok;
    ok = 1'b1;
    unique case (sel)
      ADDR_OFF: ok = 1'b1;
      ADDR_NODE: ok = (a == node);
      ADDR_NODE_ZERO: ok = (a == node) || (a == ADDR_BCAST_ZERO);
      ADDR_NODE_ALL: ok = (a == node) || (a == ADDR_BCAST_ZERO) ||
                          (a == ADDR_BCAST_ONES);
    endcase
    return ok;
  endfunction

  // ****************************************
  // Chip input synchronisers
  // ****************************************
  logic [1:0] clk_sync_q;
  logic [1:0] dat_sync_q;
  logic clk_prev_q;
  logic chip_edge;
  logic chip;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clk_sync_q <= 2'b00;
      dat_sync_q <= 2'b00;
      clk_prev_q <= 1'b0;
    end else if (ce_in) begin
      clk_sync_q <= {clk_sync_q[0], chip_clk_in};
      dat_sync_q <= {dat_sync_q[0], chip_data_in};
      clk_prev_q <= clk_sync_q[1];
    end
  end

  assign chip_edge = clk_sync_q[1] & ~clk_prev_q;
  assign chip = dat_sync_q[1];

  // ****************************************
  // Receive decode
  // ****************************************
  prx_rx_state_t rx_state_q;
  logic [31:0] sync_sh_q;
  logic half_q;
  logic first_chip_q;
  logic [6:0] byte_sh_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] byte_idx_q;
  logic [7:0] total_q;
  logic crc_idx_q;
  logic [7:0] crc_hi_q;
  logic [6:0] count_q;
  logic rx_mode, in_frame, bit_valid, raw_bit, rx_bit, byte_done;
  logic rx_wbit, sync_hit, len_field, addr_field, last_byte;
  logic discard, push, crc_final, crc_good, finish, fifo_clear;
  logic [31:0] sync_next;
  logic [7:0] rx_byte;
  logic [15:0] rx_crc;

  assign rx_mode = (mode_in == MODE_RX);
  assign in_frame = (rx_state_q == RX_BODY) || (rx_state_q == RX_CHECK);
  assign sync_next = {sync_sh_q[30:0], chip};

  assign sync_hit = chip_edge && rx_mode && (rx_state_q == RX_HUNT) &&
                    (count_q == 7'd0) &&
                    (((sync_next ^ sync_word_in) &
                      sync_mask(sync_size_in)) == 32'h0000_0000);

  always_comb begin
    bit_valid = 1'b0;
    raw_bit = chip;
    if (chip_edge && in_frame) begin
      if (!manchester_enable_in) begin
        bit_valid = 1'b1;
      end else if (half_q) begin
        bit_valid = 1'b1;
        raw_bit = first_chip_q;
      end
    end
  end

  assign rx_bit = raw_bit ^ (whitening_enable_in & rx_wbit);
  assign byte_done = bit_valid && (bit_cnt_q == 3'd7);
  assign rx_byte = {byte_sh_q, rx_bit};
  assign len_field = variable_length_in && (byte_idx_q == 7'd0);
  assign addr_field = (address_filter_select_in != ADDR_OFF) &&
                      (byte_idx_q == {6'd0, variable_length_in});
  assign last_byte = !len_field && ({1'b0, byte_idx_q} + 8'd1 == total_q);

  assign discard = byte_done && (rx_state_q == RX_BODY) &&
    ((len_field && ((rx_byte >= {1'b0, payload_length_limit_in}) ||
                    (rx_byte == 8'h00))) ||
     (addr_field &&
      !addr_match(address_filter_select_in, rx_byte, node_address_reg_in)));

  assign push = byte_done && (rx_state_q == RX_BODY) && !discard;
  assign crc_final = byte_done && (rx_state_q == RX_CHECK) && crc_idx_q;
  assign crc_good = ({crc_hi_q, rx_byte} == (rx_crc ^ CRC_FINAL_XOR));
  assign finish = (push && last_byte && !crc_check_enable_in) ||
                  (crc_final && (crc_good || crc_fail_autoclear_disable_in));
  assign fifo_clear = discard ||
    (crc_final && !crc_good && !crc_fail_autoclear_disable_in);

  prx_whiten u_rx_white (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .restart_in(sync_hit),
    .step_in(bit_valid),
    .bit_out(rx_wbit)
  );

  prx_crc16 u_rx_crc (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .restart_in(sync_hit),
    .step_in(bit_valid && (rx_state_q == RX_BODY) &&
             !(variable_length_in && (byte_idx_q == 7'd0))),
    .data_in(rx_bit),
    .crc_out(rx_crc)
  );

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_state_q <= RX_HUNT;
    end else if (ce_in) begin
      if (!rx_mode) begin
        rx_state_q <= RX_HUNT;
      end else begin
        unique case (rx_state_q)
          RX_HUNT: if (sync_hit) begin
            rx_state_q <= RX_BODY;
          end
          RX_BODY: if (discard) begin
            rx_state_q <= RX_HUNT;
          end else if (push && last_byte) begin
            rx_state_q <= crc_check_enable_in ? RX_CHECK : RX_HOLD;
          end
          RX_CHECK: if (crc_final) begin
            rx_state_q <= finish ? RX_HOLD : RX_HUNT;
          end
          RX_HOLD: rx_state_q <= RX_HOLD;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_sh_q <= 32'h0000_0000;
    end else if (ce_in) begin
      if (chip_edge && rx_state_q == RX_HUNT) begin
        sync_sh_q <= sync_next;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      half_q <= 1'b0;
      first_chip_q <= 1'b0;
      byte_sh_q <= 7'd0;
      bit_cnt_q <= 3'd0;
    end else if (ce_in) begin
      if (sync_hit) begin
        half_q <= 1'b0;
        bit_cnt_q <= 3'd0;
      end else begin
        if (chip_edge && in_frame && manchester_enable_in) begin
          half_q <= ~half_q;
          first_chip_q <= chip;
        end
        if (bit_valid) begin
          byte_sh_q <= rx_byte[6:0];
          bit_cnt_q <= 3'(bit_cnt_q + 3'd1);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte_idx_q <= 7'd0;
      total_q <= 8'd0;
      crc_idx_q <= 1'b0;
      crc_hi_q <= 8'd0;
    end else if (ce_in) begin
      if (sync_hit) begin
        byte_idx_q <= 7'd0;
        total_q <= {1'b0, payload_length_limit_in};
        crc_idx_q <= 1'b0;
      end else if (push) begin
        byte_idx_q <= 7'(byte_idx_q + 7'd1);
        if (len_field) begin
          total_q <= 8'(rx_byte + 8'd1);
        end
      end else if (byte_done && rx_state_q == RX_CHECK) begin
        crc_idx_q <= 1'b1;
        crc_hi_q <= rx_byte;
      end
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  logic payload_ready_q, crc_pass_q, sync_flag_q, crc_status_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      payload_ready_q <= 1'b0;
      crc_pass_q <= 1'b0;
      sync_flag_q <= 1'b0;
      crc_status_q <= 1'b0;
    end else if (ce_in) begin
      sync_flag_q <= sync_hit;
      if (sync_hit) begin
        payload_ready_q <= 1'b0;
        crc_pass_q <= 1'b0;
      end
      if (finish) begin
        payload_ready_q <= 1'b1;
      end
      if (crc_final) begin
        crc_pass_q <= crc_good;
        crc_status_q <= crc_good;
      end
    end
  end

  // ****************************************
  // FIFO
  // ****************************************
  logic [7:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [6:0] count_d, fifo_cap;
  logic [7:0] fifo_data_q;
  logic fifo_empty_q, push_ok, read_ok;

  // A smaller size only caps the count; the array stays full depth.
  assign fifo_cap = 7'({fifo_size_in, 4'b0000}) + FIFO_STEP;
  assign push_ok = push && (count_q < fifo_cap) && !fifo_clear;
  assign read_ok = fifo_read_in && (count_q != 7'd0) && !fifo_clear &&
                   (rx_mode || (mode_in == MODE_STANDBY &&
                                standby_fifo_access_in));

  always_comb begin
    count_d = count_q;
    if (fifo_clear) begin
      count_d = 7'd0;
    end else if (push_ok && !read_ok) begin
      count_d = 7'(count_q + 7'd1);
    end else if (read_ok && !push_ok) begin
      count_d = 7'(count_q - 7'd1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (ce_in && push_ok) begin
      mem[wr_ptr_q] <= rx_byte;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= 7'd0;
      fifo_empty_q <= 1'b1;
      fifo_data_q <= 8'h00;
    end else if (ce_in) begin
      count_q <= count_d;
      fifo_empty_q <= (count_d == 7'd0);
      if (fifo_clear) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
      end else begin
        if (push_ok) begin
          wr_ptr_q <= FIFO_AW'(wr_ptr_q + 1'b1);
        end
        if (read_ok) begin
          rd_ptr_q <= FIFO_AW'(rd_ptr_q + 1'b1);
          fifo_data_q <= mem[rd_ptr_q];
        end
      end
    end
  end

  // ****************************************
  // Transmit coding
  // ****************************************
  prx_tx_state_t tx_state_q;
  logic [7:0] tx_sh_q, tx_next_q;
  logic [2:0] tx_bits_q;
  logic [1:0] tx_src_q;
  logic tx_half_q, tx_last_q, tx_next_last_q, tx_full_q, tx_full_d;
  logic tx_ready_q, tx_chip_q, tx_done_q, tx_mode, tx_take, tx_start;
  logic tx_adv, tx_byte_end, tx_load, tx_wbit, tx_wb, tx_chip;
  logic [15:0] tx_crc, tx_crc_val;

  assign tx_mode = (mode_in == MODE_TX);
  assign tx_take = tx_valid_in && tx_ready_q;
  assign tx_start = (tx_state_q == TX_IDLE) && tx_mode && tx_full_q;
  assign tx_adv = chip_edge && (tx_state_q == TX_SEND) &&
                  (!manchester_enable_in || tx_half_q);
  assign tx_byte_end = tx_adv && (tx_bits_q == 3'd7);
  assign tx_load = tx_start || (tx_byte_end && tx_src_q == SRC_PAY &&
                                !tx_last_q && tx_full_q);
  assign tx_wb = tx_sh_q[7] ^ (whitening_enable_in & tx_wbit);
  assign tx_chip = (manchester_enable_in && tx_half_q) ? ~tx_wb : tx_wb;
  assign tx_crc_val = tx_crc ^ CRC_FINAL_XOR;
  assign tx_full_d = tx_take ? 1'b1 : (tx_load ? 1'b0 : tx_full_q);

  prx_whiten u_tx_white (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .restart_in(tx_start),
    .step_in(tx_adv),
    .bit_out(tx_wbit)
  );

  prx_crc16 u_tx_crc (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .restart_in(tx_start),
    .step_in(tx_adv && tx_src_q == SRC_PAY),
    .data_in(tx_sh_q[7]),
    .crc_out(tx_crc)
  );

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_next_q <= 8'h00;
      tx_next_last_q <= 1'b0;
      tx_full_q <= 1'b0;
      tx_ready_q <= 1'b0;
    end else if (ce_in) begin
      tx_full_q <= tx_mode && tx_full_d;
      tx_ready_q <= tx_mode && !tx_full_d;
      if (tx_take) begin
        tx_next_q <= tx_byte_in;
        tx_next_last_q <= tx_last_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_state_q <= TX_IDLE;
      tx_src_q <= SRC_PAY;
      tx_done_q <= 1'b0;
    end else if (ce_in) begin
      tx_done_q <= (tx_state_q == TX_FIN);
      if (!tx_mode) begin
        tx_state_q <= TX_IDLE;
      end else begin
        unique case (tx_state_q)
          TX_IDLE: if (tx_start) begin
            tx_state_q <= TX_SEND;
            tx_src_q <= SRC_PAY;
          end
          TX_SEND: if (tx_byte_end && !tx_load) begin
            if (tx_src_q == SRC_PAY && tx_last_q && crc_check_enable_in) begin
              tx_state_q <= TX_LOAD;
            end else if (tx_src_q == SRC_CRC_HI) begin
              tx_src_q <= SRC_CRC_LO;
            end else begin
              tx_state_q <= TX_FIN;
            end
          end
          TX_LOAD: begin
            tx_state_q <= TX_SEND;
            tx_src_q <= SRC_CRC_HI;
          end
          TX_FIN: tx_state_q <= TX_IDLE;
        endcase
      end
    end
  end

  // Chips 10 for one, 01 for zero.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_sh_q <= 8'h00;
      tx_bits_q <= 3'd0;
      tx_half_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_chip_q <= 1'b0;
    end else if (ce_in) begin
      if (tx_load) begin
        tx_sh_q <= tx_next_q;
        tx_last_q <= tx_next_last_q;
      end else if (tx_state_q == TX_LOAD) begin
        tx_sh_q <= tx_crc_val[15:8];
      end else if (tx_byte_end && tx_src_q == SRC_CRC_HI) begin
        tx_sh_q <= tx_crc_val[7:0];
      end else if (tx_adv) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
      if (tx_start) begin
        tx_bits_q <= 3'd0;
        tx_half_q <= 1'b0;
      end else begin
        if (tx_adv) begin
          tx_bits_q <= 3'(tx_bits_q + 3'd1);
        end
        if (chip_edge && tx_state_q == TX_SEND && manchester_enable_in) begin
          tx_half_q <= ~tx_half_q;
        end
      end
      if (chip_edge && tx_state_q == TX_SEND) begin
        tx_chip_q <= tx_chip;
      end else if (tx_state_q == TX_IDLE) begin
        tx_chip_q <= 1'b0;
      end
    end
  end

  assign fifo_data_out = fifo_data_q;
  assign fifo_empty_out = fifo_empty_q;
  assign payload_ready_flag_out = payload_ready_q;
  assign crc_pass_flag_out = crc_pass_q;
  assign sync_flag_out = sync_flag_q;
  assign crc_status_bit_out = crc_status_q;
  assign tx_ready_out = tx_ready_q;
  assign tx_chip_out = tx_chip_q;
  assign tx_done_out = tx_done_q;
endmodule

// >>> inc/prx_pkg.sv
package prx_pkg;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_RX = 2'b10,
    MODE_TX = 2'b11
  } prx_mode_t;

  // ****************************************
  // Receive and transmit states
  // ****************************************
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_BODY = 2'b01,
    RX_CHECK = 2'b11,
    RX_HOLD = 2'b10
  } prx_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_LOAD = 2'b11,
    TX_FIN = 2'b10
  } prx_tx_state_t;

  localparam logic [1:0] SRC_PAY = 2'b00;
  localparam logic [1:0] SRC_CRC_HI = 2'b01;
  localparam logic [1:0] SRC_CRC_LO = 2'b10;

  // ****************************************
  // Filtering and FIFO constants
  // ****************************************
  localparam logic [1:0] ADDR_OFF = 2'b00;
  localparam logic [1:0] ADDR_NODE = 2'b01;
  localparam logic [1:0] ADDR_NODE_ZERO = 2'b10;
  localparam logic [1:0] ADDR_NODE_ALL = 2'b11;
  localparam logic [7:0] ADDR_BCAST_ZERO = 8'h00;
  localparam logic [7:0] ADDR_BCAST_ONES = 8'hFF;
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW = 6;
  localparam logic [6:0] FIFO_STEP = 7'h10;

  // ****************************************
  // Coding constants
  // ****************************************
  // Preset and final inversion both all ones, so zeros at either end
  // of the payload still change the checksum.
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_FINAL_XOR = 16'hFFFF;
  localparam logic [8:0] WHITE_TAPS = 9'h021;
  localparam logic [8:0] WHITE_SEED = 9'h1FF;

endpackage

// >>> rtl/prx_whiten.sv
`timescale 1ns/1ps
module prx_whiten (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic restart_in,
  input wire logic step_in,
  output logic bit_out
);
  import prx_pkg::*;

  logic [8:0] lfsr_q;
  logic feedback;

  assign feedback = ^(lfsr_q & WHITE_TAPS);
  assign bit_out = lfsr_q[0];

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lfsr_q <= WHITE_SEED;
    end else if (ce_in) begin
      if (restart_in) begin
        lfsr_q <= WHITE_SEED;
      end else if (step_in) begin
        lfsr_q <= {feedback, lfsr_q[8:1]};
      end
    end
  end
endmodule

// >>> rtl/prx_crc16.sv
`timescale 1ns/1ps
module prx_crc16 (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic restart_in,
  input wire logic step_in,
  input wire logic data_in,
  output logic [15:0] crc_out
);
  import prx_pkg::*;

  logic [15:0] crc_q;
  logic feedback;

  assign feedback = crc_q[15] ^ data_in;
  assign crc_out = crc_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      crc_q <= CRC_PRESET;
    end else if (ce_in) begin
      if (restart_in) begin
        crc_q <= CRC_PRESET;
      end else if (step_in) begin
        crc_q <= {crc_q[14:0], 1'b0} ^ (feedback ? CRC_POLY : 16'h0000);
      end
    end
  end
endmodule

// >>> tb/prx_packet_rx_checker.sv
`timescale 1ns/1ps
module prx_packet_rx_checker (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input prx_pkg::prx_mode_t mode_in,
  input wire logic fifo_read_in,
  input wire logic [7:0] fifo_data_out,
  input wire logic fifo_empty_out,
  input wire logic payload_ready_flag_out,
  input wire logic crc_pass_flag_out,
  input wire logic sync_flag_out,
  input wire logic crc_status_bit_out,
  input wire logic crc_check_enable_in,
  input wire logic crc_fail_autoclear_disable_in
);
  import prx_pkg::*;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ****************
  // Assertions
  // ****************
  sync_pulse_a: assert property (sync_flag_out |=> !sync_flag_out)
    else $error("sync pulse too long");
  sync_hunt_a: assert property (sync_flag_out |-> fifo_empty_out &&
    mode_in == MODE_RX) else $error("sync outside empty rx");
  read_refused_a: assert property (fifo_read_in &&
    (fifo_empty_out || mode_in == MODE_SLEEP) |=> $stable(fifo_data_out))
    else $error("refused read changed data");
  pass_status_a: assert property (crc_pass_flag_out |-> crc_status_bit_out)
    else $error("pass without status");
  pass_enable_a: assert property ($rose(crc_pass_flag_out) |->
    crc_check_enable_in) else $error("pass with check off");
  pass_ready_a: assert property ($rose(crc_pass_flag_out) |->
    payload_ready_flag_out) else $error("pass without ready");
  autoclear_fail_a: assert property ($rose(payload_ready_flag_out) &&
    crc_check_enable_in && !crc_fail_autoclear_disable_in |->
    crc_pass_flag_out) else $error("ready on failed check");
  ready_data_a: assert property ($rose(payload_ready_flag_out) |->
    !fifo_empty_out) else $error("ready with empty fifo");
  cover property (sync_flag_out);
  cover property ($rose(payload_ready_flag_out) && crc_pass_flag_out);
  cover property ($rose(payload_ready_flag_out) && !crc_pass_flag_out);
endmodule

bind prx_packet_rx prx_packet_rx_checker i_chk (.*);

// >>> tb/prx_host_model.sv
`timescale 1ns/1ps
module prx_host_model (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic drain_in,
  input wire logic fifo_empty_in,
  input wire logic [7:0] fifo_data_in,
  output logic fifo_read_out
);
  logic pend_q;
  logic [7:0] got[$];
  // ****************
  // Reader
  // ****************
  // standby fifo reads
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fifo_read_out <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (pend_q)
        got.push_back(fifo_data_in);
      pend_q <= fifo_read_out && !fifo_empty_in;
      fifo_read_out <= drain_in;
    end
  end
endmodule

// >>> tb/prx_packet_rx_tb.sv
`timescale 1ns/1ps
module prx_packet_rx_tb;
  import prx_pkg::*;
  logic ref_clk_in = 0, reset_n_in = 0, ce_in = 1, chip_clk_in = 0;
  logic chip_data_in = 0, variable_length_in = 1, drain = 0;
  logic crc_check_enable_in = 0, crc_fail_autoclear_disable_in = 0;
  logic standby_fifo_access_in = 0, manchester_enable_in = 0;
  logic whitening_enable_in = 0, tx_valid_in = 0, tx_last_in = 0;
  logic fifo_read_in, fifo_empty_out, payload_ready_flag_out;
  logic crc_pass_flag_out, sync_flag_out, crc_status_bit_out;
  logic tx_ready_out, tx_chip_out, tx_done_out;
  logic [1:0] sync_size_in = 2'h1, fifo_size_in = 2'h0;
  logic [1:0] address_filter_select_in = 2'h0;
  logic [6:0] payload_length_limit_in = 7'h0C;
  logic [7:0] node_address_reg_in = 8'h5A, tx_byte_in = 8'h00;
  logic [7:0] fifo_data_out;
  logic [8:0] wl;
  logic [31:0] sync_word_in = 32'h0000_3C96;
  prx_mode_t mode_in = MODE_RX;
  int num_errors = 0, num_checks = 0, nsync = 0, cyc = 0;

  prx_packet_rx i_dut (.*);
  prx_host_model i_host (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .drain_in(drain), .fifo_empty_in(fifo_empty_out),
    .fifo_data_in(fifo_data_out), .fifo_read_out(fifo_read_in));

  initial forever #20 ref_clk_in = ~ref_clk_in;

  // ****************
  // Helpers
  // ****************
  task report_and_stop;
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hang costs one mismatch, then the run closes.
  always @(posedge ref_clk_in) begin
    cyc++;
    nsync += (sync_flag_out === 1'b1);
    if (cyc == 90000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Chip clock idles low; data settles two cycles before each rise.
  task chip(input logic b);
    @(posedge ref_clk_in) chip_data_in <= b;
    repeat (2) @(posedge ref_clk_in);
    chip_clk_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    chip_clk_in <= 1'b0;
  endtask

  task send_byte(input logic [7:0] v, input logic man);
    for (int k = 7; k >= 0; k--) begin
      chip(v[k]);
      if (man)
        chip(!v[k]);
    end
  endtask

  task wb(input logic [7:0] v);
    logic [7:0] w;
    for (int k = 7; k >= 0; k--) begin
      w[k] = v[k] ^ (whitening_enable_in & wl[0]);
      wl = {^(wl & WHITE_TAPS), wl[8:1]};
    end
    send_byte(w, manchester_enable_in);
  endtask

  task send(input logic [7:0] p[$], input logic [15:0] c, input logic bs);
    logic [15:0] s;
    s = sync_word_in[15:0] ^ (bs ? 16'h0100 : 16'h0000);
    wl = WHITE_SEED;
    send_byte(8'hAA, 1'b0);
    send_byte(s[15:8], 1'b0);
    send_byte(s[7:0], 1'b0);
    foreach (p[k])
      wb(p[k]);
    if (crc_check_enable_in) begin
      wb(c[15:8]);
      wb(c[7:0]);
    end
  endtask

  // preset and inverted, length byte excluded
  function logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 1; i < b.size(); i++)
      for (int k = 7; k >= 0; k--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? 16'h1021 : 16'h0000);
    return ~c;
  endfunction

  function logic accept(input logic [1:0] am, input logic [7:0] a,
    input int l, input int lim, input logic [7:0] nd, input logic ce,
    input logic bad, input logic acd);
    return l > 0 && l < lim && (am == 2'h0 || a == nd ||
      (am[1] && a == 8'h00) || (am == 2'h3 && a == 8'hFF)) &&
      !(ce && bad && !acd);
  endfunction

  // ****************
  // Scenarios
  // ****************
  initial begin
    logic [7:0] pk[$];
    logic [7:0] a, nd;
    logic [1:0] am;
    logic bs, bad, ok, ce, acd;
    int l, lim, n0;
    void'($urandom(73895));
    repeat (5) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      am = 2'(i % 4);
      nd = 8'($urandom_range(1, 254));
      lim = i == 4 ? 16 : $urandom_range(4, 15);
      a = (i / 4) % 4 == 0 ? nd : (i / 4) % 4 == 1 ? 8'h00 :
        (i / 4) % 4 == 2 ? 8'hFF : 8'($urandom_range(1, 254));
      l = i == 16 ? lim - 1 : i == 20 ? lim : i == 8 ? 0 :
        $urandom_range(1, lim - 1);
      bs = (i == 9);
      bad = (i % 5 == 2);
      acd = (i % 3 == 0);
      ce = (i % 6 != 1);
      pk.delete();
      pk.push_back(8'(l));
      for (int k = 0; k < l; k++)
        pk.push_back(k == 0 ? a : 8'($urandom));
      ok = accept(am, a, l, lim, nd, ce, bad, acd);
      @(posedge ref_clk_in);
      address_filter_select_in <= am;
      node_address_reg_in <= nd;
      payload_length_limit_in <= 7'(lim);
      fifo_size_in <= i == 4 ? 2'h0 : 2'($urandom);
      crc_check_enable_in <= ce;
      crc_fail_autoclear_disable_in <= acd;
      manchester_enable_in <= (i % 7 == 3);
      whitening_enable_in <= (i % 7 == 5);
      n0 = nsync;
      send(pk, crc16(pk) ^ (bad ? 16'h0001 : 16'h0000), bs);
      for (int k = 0; k < 20 && payload_ready_flag_out !== 1'b1; k++)
        @(posedge ref_clk_in);
      chk(8'(nsync - n0), 8'(!bs));
      if (!bs)
        chk(8'(payload_ready_flag_out), 8'(ok));
      if (!ok)
        chk(8'(fifo_empty_out), 8'h01);
      else begin
        chk(8'(crc_pass_flag_out), 8'(ce && !bad));
        if (ce)
          chk(8'(crc_status_bit_out), 8'(!bad));
        n0 = nsync;
        send(pk, 16'h0000, 1'b0);
        chk(8'(nsync - n0), 8'h00);
        mode_in <= MODE_SLEEP;
        drain <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        drain <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        mode_in <= MODE_STANDBY;
        standby_fifo_access_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        i_host.got.delete();
        drain <= 1'b1;
        for (int k = 0; k < 100 && i_host.got.size() < pk.size(); k++)
          @(posedge ref_clk_in);
        drain <= 1'b0;
        chk(8'(i_host.got.size()), 8'(pk.size()));
        foreach (pk[k])
          chk(i_host.got[k], pk[k]);
        mode_in <= MODE_RX;
        standby_fifo_access_in <= 1'b0;
      end
    end
    mode_in <= MODE_TX;
    tx_byte_in <= 8'($urandom);
    tx_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    while (tx_ready_out !== 1'b1)
      @(posedge ref_clk_in);
    tx_valid_in <= 1'b0;
    for (int k = 7; k >= 0; k--) begin
      chip(1'b0);
      @(negedge ref_clk_in) a[k] = tx_chip_out;
    end
    chk(a, tx_byte_in);
    @(negedge ref_clk_in);
    chk(8'(tx_done_out), 8'h01);
    report_and_stop();
  end
endmodule
